/* File: rtl/ebp_defs.svh */
// Purpose: shared constants of the bridge pwm output stage
// Assumes: mclk is the oscillator clock, 40 MHz, 25 ns period
// Notes:   select and config codes, offsets of bit fields, reset values and timing counts only
//
// Contract
// - Period is (period_limit+1) times four oscillator periods times prescale factor.
// - After timer equals limit: clear timer, set output unless duty zero, load duty.
// - Timer postscaler never affects pwm frequency, only its own tick rate.
// - Duty is 10 bits: eight high bits plus two low control bits.
// - Duty writes accepted anytime, applied at period match; active duty read-only.
// - Output clears when active duty equals timer extended by two fine bits.
// - Duty beyond period never clears output, giving constant active level.
// - Two-bit config selects single 00, half-bridge 10, full forward, full reverse.
// - Half-bridge drives modulated signal on A and its complement on B.
// - Half-bridge delays each rising edge by dead-band count instruction cycles.
// - Dead-band longer than active time keeps that output inactive whole cycle.
// - Full forward: A held active, D modulated, B and C inactive.
// - Full reverse: C held active, B modulated, A and D inactive.
// - Full-bridge direction change takes effect with the next pwm cycle.
// - On direction change, B and D idle and A/C swap one prescaled cycle early.
// - Prescale factor 1, 4 or 16 chosen by a two-bit select.
// - No dead-band delay in either full-bridge mode, even at direction change.
// - Controls double-buffered at period start; dead-band also at duty boundary.
// - Low two mode bits pick active-high or active-low polarity for outputs.
`ifndef EBP_DEFS_SVH
`define EBP_DEFS_SVH

// ==========================================================
// timing
`define EBP_CLK_PERIOD_NS  25
`define EBP_TOSC_NS        25
`define EBP_TOSC_PER_TCY   4
`define EBP_TCY_CYCLES     ((`EBP_TOSC_PER_TCY * `EBP_TOSC_NS) / `EBP_CLK_PERIOD_NS)

// ==========================================================
// prescaler select codes and terminal counts
`define EBP_PSC_SEL_1      2'h0
`define EBP_PSC_SEL_4      2'h1
`define EBP_PSC_TOP_1      4'h0
`define EBP_PSC_TOP_4      4'h3
`define EBP_PSC_TOP_16     4'hF

// ==========================================================
// output configuration codes
`define EBP_CFG_SINGLE     2'h0
`define EBP_CFG_FWD        2'h1
`define EBP_CFG_HALF       2'h2
`define EBP_CFG_REV        2'h3
`define EBP_CFG_DIR_BIT    1

// ==========================================================
// mode bits: [3:2] select pwm, [1] pair A/C low, [0] pair B/D low
`define EBP_MODE_PWM       2'h3
`define EBP_MODE_HI_MSB    3
`define EBP_MODE_HI_LSB    2
`define EBP_POL_AC_BIT     1
`define EBP_POL_BD_BIT     0

// ==========================================================
// reset values
`define EBP_DUTY_RST       10'h000
`define EBP_DB_RST         7'h00
`define EBP_MODE_RST       4'h0

`endif

/* File: rtl/ebp_pkg.sv */
// Purpose: types of the bridge pwm output stage
// Assumes: used together with ebp_defs.svh
// Notes:   values live in the header, types here
package ebp_pkg;

	// decoded output configuration
	typedef enum logic [1:0] {
		EBP_SINGLE,
		EBP_HALF,
		EBP_FWD,
		EBP_REV
	} ebp_mode_t;

	// dead-band channel state
	typedef enum logic [1:0] {
		EBP_DB_IDLE,
		EBP_DB_WAIT,
		EBP_DB_ON
	} ebp_db_state_t;

endpackage

/* File: rtl/ebp_timebase.sv */
// Purpose: period timer with quarter-cycle clock, prescaler and postscaler
// Assumes: mclk is the oscillator clock; instruction cycle is four mclk
// Notes:   all outputs registered; post_tick divides the period match rate and never feeds the pwm
`timescale 1ns/1ps
`include "ebp_defs.svh"

module ebp_timebase
	import ebp_pkg::*;
#(
	parameter int TW = 8
) (
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic          ce,
	input  wire logic [1:0]    prescale_sel,
	input  wire logic [TW-1:0] period_limit,
	input  wire logic [3:0]    postscale_sel,
	output logic      [TW-1:0] period_timer,
	output logic      [1:0]    fine_lo,
	output logic               period_start,
	output logic               tcy_tick,
	output logic               post_tick
);

	logic [1:0]    q_reg, q_next;
	logic [3:0]    psc_reg, psc_next;
	logic [TW-1:0] tmr_reg, tmr_next;
	logic [3:0]    post_reg, post_next;
	logic [1:0]    lo_reg, lo_next;
	logic          start_reg, start_next;
	logic          tick_reg, tick_next;
	logic          ptick_reg, ptick_next;
	logic          inc;

	// terminal count of the prescaler for a select code
	function automatic logic [3:0] psc_top(input logic [1:0] sel);
		if (sel == `EBP_PSC_SEL_1)
			return `EBP_PSC_TOP_1;
		else if (sel == `EBP_PSC_SEL_4)
			return `EBP_PSC_TOP_4;
		else
			return `EBP_PSC_TOP_16;
	endfunction

	// two fine bits below the timer: quarter clock or prescaler bits
	function automatic logic [1:0] fine_bits(input logic [1:0] sel, input logic [1:0] q, input logic [3:0] p);
		if (sel == `EBP_PSC_SEL_1)
			return q;
		else if (sel == `EBP_PSC_SEL_4)
			return p[1:0];
		else
			return p[3:2];
	endfunction

	// ==========================================================
	// next state of the time base
	always_comb begin
		tick_next  = (q_reg == 2'(`EBP_TCY_CYCLES - 1));
		q_next     = tick_next ? 2'h0 : q_reg + 2'h1;
		inc        = tick_next && (psc_reg == psc_top(prescale_sel));
		psc_next   = psc_reg;
		tmr_next   = tmr_reg;
		start_next = 1'b0;
		post_next  = post_reg;
		ptick_next = 1'b0;
		if (tick_next)
			psc_next = inc ? 4'h0 : psc_reg + 4'h1;
		if (inc) begin
			if (tmr_reg == period_limit) begin
				tmr_next   = '0;
				start_next = 1'b1;
			end else begin
				tmr_next = tmr_reg + TW'(1);
			end
		end
		// postscaler only divides the match rate, pwm never sees it
		if (start_next) begin
			if (post_reg == postscale_sel) begin
				post_next  = 4'h0;
				ptick_next = 1'b1;
			end else begin
				post_next = post_reg + 4'h1;
			end
		end
		lo_next = fine_bits(prescale_sel, q_next, psc_next);
	end

	// registers of the time base, frozen while ce is low
	always_ff @(posedge mclk) begin
		if (rst) begin
			q_reg     <= 2'h0;
			psc_reg   <= 4'h0;
			tmr_reg   <= '0;
			post_reg  <= 4'h0;
			lo_reg    <= 2'h0;
			start_reg <= 1'b0;
			tick_reg  <= 1'b0;
			ptick_reg <= 1'b0;
		end else if (ce) begin
			q_reg     <= q_next;
			psc_reg   <= psc_next;
			tmr_reg   <= tmr_next;
			post_reg  <= post_next;
			lo_reg    <= lo_next;
			start_reg <= start_next;
			tick_reg  <= tick_next;
			ptick_reg <= ptick_next;
		end
	end

	assign period_timer = tmr_reg;
	assign fine_lo      = lo_reg;
	assign period_start = start_reg;
	assign tcy_tick     = tick_reg;
	assign post_tick    = ptick_reg;

endmodule

/* File: rtl/ebp_top.sv */
// Purpose: enhanced bridge pwm output stage, four outputs A to D
// Assumes: control bits arrive as plain ports, synchronous to mclk
// Notes:   output enable high while a pin is driven; unused pins float
`timescale 1ns/1ps
`include "ebp_defs.svh"

// ==========================================================
// pin map: bit 0 is A, bit 1 B, bit 2 C, bit 3 D
// latency: internal level to pin is one clock
// limitation: period_limit is used live, so moving it
// mid period can stretch or cut that one period
// trade-off: one prescaled count of swap time, no dead-band

module ebp_top
	import ebp_pkg::*;
#(
	parameter int TW  = 8,
	parameter int DW  = 10,
	parameter int DBW = 7
) (
	input  wire logic           mclk,
	input  wire logic           rst,
	input  wire logic           ce,
	input  wire logic [3:0]     polarity_mode_bits,
	input  wire logic [1:0]     output_config_field,
	input  wire logic [TW-1:0]  duty_pending,
	input  wire logic [1:0]     duty_low_bits,
	input  wire logic [TW-1:0]  period_limit,
	input  wire logic [1:0]     timer_prescale_select,
	input  wire logic [3:0]     postscale_select,
	input  wire logic [DBW-1:0] deadband_count,
	input  wire logic           pin_dir_a,
	input  wire logic           pin_dir_b,
	input  wire logic           pin_dir_c,
	input  wire logic           pin_dir_d,
	output logic                out_a,
	output logic                out_b,
	output logic                out_c,
	output logic                out_d,
	output logic                out_a_oe,
	output logic                out_b_oe,
	output logic                out_c_oe,
	output logic                out_d_oe,
	output logic [DW-1:0]       duty_active,
	output logic [TW-1:0]       period_timer,
	output logic                post_tick
);

	// ==========================================================
	// helpers

	// configuration field to mode; high bit doubles as direction
	function automatic ebp_mode_t cfg_mode(input logic [1:0] cfg);
		case (cfg)
			`EBP_CFG_SINGLE: return EBP_SINGLE;
			`EBP_CFG_HALF:   return EBP_HALF;
			`EBP_CFG_FWD:    return EBP_FWD;
			`EBP_CFG_REV:    return EBP_REV;
			default:         return EBP_SINGLE;
		endcase
	endfunction

	// active level to pin level under the chosen polarity
	function automatic logic pin_level(input logic active, input logic act_low);
		return act_low ? ~active : active;
	endfunction

	// ==========================================================
	// time base
	// period_start: one clock wide, first count of a period
	// tcy_tick: one clock per instruction cycle
	logic [1:0] fine_lo;
	logic       period_start;
	logic       tcy_tick;

	// post_tick leaves straight out; it never feeds the pwm
	ebp_timebase #(
		.TW (TW)
	) u_timebase (
		.mclk          (mclk),
		.rst           (rst),
		.ce            (ce),
		.prescale_sel  (timer_prescale_select),
		.period_limit  (period_limit),
		.postscale_sel (postscale_select),
		.period_timer  (period_timer),
		.fine_lo       (fine_lo),
		.period_start  (period_start),
		.tcy_tick      (tcy_tick),
		.post_tick     (post_tick)
	);

	// ==========================================================
	// double-buffered controls
	// shadow copies of the live controls
	logic [1:0]     cfg_reg, cfg_next;
	logic [3:0]     mode_reg, mode_next;
	logic [DW-1:0]  duty_reg, duty_next;
	logic [DBW-1:0] db_reg, db_next;
	logic [DW-1:0]  duty_new;
	logic           duty_match;
	logic           pwm_on;
	logic           pwm_req;

	// the full duty value is the eight high bits then the two low bits
	assign duty_new = {duty_pending, duty_low_bits};
	assign pwm_on   = (mode_reg[`EBP_MODE_HI_MSB:`EBP_MODE_HI_LSB] == `EBP_MODE_PWM);
	// live request: turn-on still waits for a period start
	assign pwm_req  = (polarity_mode_bits[`EBP_MODE_HI_MSB:`EBP_MODE_HI_LSB] == `EBP_MODE_PWM);
	// duty boundary: fine position meets the active duty
	assign duty_match = pwm_on && !period_start && ({period_timer, fine_lo} == duty_reg);

	// controls change at period start, dead-band also at duty match, so no glitch mid cycle
	always_comb begin
		cfg_next  = cfg_reg;
		mode_next = mode_reg;
		duty_next = duty_reg;
		db_next   = db_reg;
		if (period_start) begin
			cfg_next  = output_config_field;
			mode_next = polarity_mode_bits;
			duty_next = duty_new;
			db_next   = deadband_count;
		end else if (duty_match) begin
			// dead-band may refresh at the duty boundary too
			db_next = deadband_count;
		end
		// mode and config writes outside the pwm mode take effect at once
		if (!pwm_on && !pwm_req) begin
			mode_next = polarity_mode_bits;
			cfg_next  = output_config_field;
		end
	end

	// control registers; duty_reg has no write path of its own
	// ce low freezes the shadows together with the timer
	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_reg  <= `EBP_CFG_SINGLE;
			mode_reg <= `EBP_MODE_RST;
			duty_reg <= `EBP_DUTY_RST;
			db_reg   <= `EBP_DB_RST;
		end else if (ce) begin
			cfg_reg  <= cfg_next;
			mode_reg <= mode_next;
			duty_reg <= duty_next;
			db_reg   <= db_next;
		end
	end

	// ==========================================================
	// modulated signal
	// one level for all configurations; delay and polarity follow
	logic mod_reg, mod_next;

	// set at period start unless duty is zero, cleared on duty match;
	// a duty past the period never matches, so the level stays active
	always_comb begin
		mod_next = mod_reg;
		if (!pwm_on)
			mod_next = 1'b0;
		else if (period_start)
			mod_next = (duty_new != '0);
		else if (duty_match)
			mod_next = 1'b0;
	end

	// modulated signal register
	always_ff @(posedge mclk) begin
		if (rst)
			mod_reg <= 1'b0;
		else if (ce)
			mod_reg <= mod_next;
	end

	// ==========================================================
	// dead-band delay, channel 0 for A, channel 1 for B
	// per channel: state and remaining instruction cycles
	ebp_db_state_t  db_st_reg  [2];
	ebp_db_state_t  db_st_next [2];
	logic [DBW-1:0] db_cnt_reg  [2];
	logic [DBW-1:0] db_cnt_next [2];
	logic [1:0]     db_raw;
	logic [1:0]     db_out;

	// B only asks for on while pwm runs, so it rests low when off
	assign db_raw = {~mod_reg & pwm_on, mod_reg};

	// each channel holds off its rising edge for db_reg instruction cycles;
	// a raw pulse shorter than the delay never shows
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			db_st_next[i]  = db_st_reg[i];
			db_cnt_next[i] = db_cnt_reg[i];
			db_out[i]      = (db_st_reg[i] == EBP_DB_ON);
			case (db_st_reg[i])
				EBP_DB_IDLE: begin
					if (db_raw[i]) begin
						// zero count: no delay at all
						if (db_reg == '0) begin
							db_st_next[i] = EBP_DB_ON;
						end else begin
							db_st_next[i]  = EBP_DB_WAIT;
							db_cnt_next[i] = db_reg;
						end
					end
				end
				EBP_DB_WAIT: begin
					if (!db_raw[i]) begin
						db_st_next[i] = EBP_DB_IDLE;
					end else if (tcy_tick) begin
						// counting on ticks keeps the delay unit at four clocks
						if (db_cnt_reg[i] == DBW'(1))
							db_st_next[i] = EBP_DB_ON;
						db_cnt_next[i] = db_cnt_reg[i] - DBW'(1);
					end
				end
				EBP_DB_ON: begin
					if (!db_raw[i])
						db_st_next[i] = EBP_DB_IDLE;
				end
				default: begin
					db_st_next[i] = EBP_DB_IDLE;
				end
			endcase
		end
	end

	// dead-band registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < 2; i++) begin
				db_st_reg[i]  <= EBP_DB_IDLE;
				db_cnt_reg[i] <= '0;
			end
		end else if (ce) begin
			for (int i = 0; i < 2; i++) begin
				db_st_reg[i]  <= db_st_next[i];
				db_cnt_reg[i] <= db_cnt_next[i];
			end
		end
	end

	// ==========================================================
	// full-bridge direction
	// pending direction is read live so the swap can start early
	// hazard: a swap at high duty can shoot through; software cuts duty first
	ebp_mode_t mode_act;
	logic      full_bridge;
	logic      dir_pend;
	logic      dir_switch;
	logic      dir_eff;

	assign mode_act    = cfg_mode(cfg_reg);
	assign full_bridge = (mode_act == EBP_FWD) || (mode_act == EBP_REV);
	assign dir_pend    = output_config_field[`EBP_CFG_DIR_BIT];
	// last prescaled timer count before the boundary: swap early
	assign dir_switch  = full_bridge && (cfg_mode(output_config_field) != EBP_SINGLE)
		&& (cfg_mode(output_config_field) != EBP_HALF)
		&& (dir_pend != cfg_reg[`EBP_CFG_DIR_BIT]) && (period_timer == period_limit);
	// new direction owns A/C during the switch, then for the next cycle
	assign dir_eff = dir_switch ? dir_pend : cfg_reg[`EBP_CFG_DIR_BIT];

	// ==========================================================
	// pin drive
	// per pin: bit 0 is A up to bit 3 for D
	logic [3:0]    act_next;
	logic [3:0]    use_next;
	logic [3:0]    lvl_reg, lvl_next;
	logic [3:0]    oe_reg, oe_next;
	logic [3:0]    pin_dir;
	logic [3:0]    pol_low;

	assign pin_dir = {pin_dir_d, pin_dir_c, pin_dir_b, pin_dir_a};
	assign pol_low = {mode_reg[`EBP_POL_BD_BIT], mode_reg[`EBP_POL_AC_BIT],
		mode_reg[`EBP_POL_BD_BIT], mode_reg[`EBP_POL_AC_BIT]};

	// active levels and pin use per configuration
	always_comb begin
		act_next = 4'h0;
		use_next = 4'h0;
		case (mode_act)
			EBP_SINGLE: begin
				// only A is used; B to D stay with the port
				use_next    = 4'h1;
				act_next[0] = mod_reg;
			end
			EBP_HALF: begin
				// A follows the level, B its complement, both delayed
				use_next    = 4'h3;
				act_next[0] = db_out[0];
				act_next[1] = db_out[1];
			end
			EBP_FWD, EBP_REV: begin
				use_next = 4'hF;
				// no dead-band here, even while swapping direction
				if (!dir_eff) begin
					act_next[0] = 1'b1;
					act_next[3] = mod_reg && !dir_switch;
				end else begin
					act_next[2] = 1'b1;
					act_next[1] = mod_reg && !dir_switch;
				end
			end
			default: begin
				use_next = 4'h0;
			end
		endcase
	end

	// enable follows use, pwm mode and pin direction; level gets polarity
	// an input pin is never driven, whatever the mode
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			oe_next[i]  = pwm_on && use_next[i] && !pin_dir[i];
			lvl_next[i] = oe_next[i] ? pin_level(act_next[i], pol_low[i]) : 1'b0;
		end
	end

	// pin registers: one flop per level and per enable
	// reset drops every enable, so board pulls hold the switches off
	always_ff @(posedge mclk) begin
		if (rst) begin
			lvl_reg <= 4'h0;
			oe_reg  <= 4'h0;
		end else if (ce) begin
			lvl_reg <= lvl_next;
			oe_reg  <= oe_next;
		end
	end

	// every output comes straight from a flop
	assign out_a       = lvl_reg[0];
	assign out_b       = lvl_reg[1];
	assign out_c       = lvl_reg[2];
	assign out_d       = lvl_reg[3];
	assign out_a_oe    = oe_reg[0];
	assign out_b_oe    = oe_reg[1];
	assign out_c_oe    = oe_reg[2];
	assign out_d_oe    = oe_reg[3];
	assign duty_active = duty_reg;

endmodule

/* File: verif/ebp_top_asserts.sv */
// Purpose: concurrent checks on the ports of the bridge pwm output stage
// Assumes: ce held high by the bench; mode checks need active-high polarity
// Notes:   a calm counter gates the steady-state mode checks until buffers settle
`timescale 1ns/1ps
`include "ebp_defs.svh"

module ebp_top_asserts #(
	parameter int TW  = 8,
	parameter int DW  = 10,
	parameter int DBW = 7
) (
	input wire logic           mclk,
	input wire logic           rst,
	input wire logic [3:0]     polarity_mode_bits,
	input wire logic [1:0]     output_config_field,
	input wire logic [TW-1:0]  period_limit,
	input wire logic [1:0]     timer_prescale_select,
	input wire logic [DBW-1:0] deadband_count,
	input wire logic           pin_dir_a,
	input wire logic           pin_dir_b,
	input wire logic           out_a,
	input wire logic           out_b,
	input wire logic           out_c,
	input wire logic           out_d,
	input wire logic           out_a_oe,
	input wire logic           out_b_oe,
	input wire logic           out_c_oe,
	input wire logic [DW-1:0]  duty_active,
	input wire logic [TW-1:0]  period_timer,
	input wire logic           post_tick
);
	localparam int HOLD = 600;

	logic [TW+DBW+9:0] ctl_reg;
	logic [TW+DBW+9:0] ctl_next;
	logic [10:0]       calm_reg;
	logic [10:0]       calm_next;
	logic              calm;

	// ==========================================================
	// calm counter
	// cycles since any control but duty, postscale or C/D direction moved; saturates so long runs never wrap
	always_comb begin
		ctl_next  = {polarity_mode_bits, output_config_field, period_limit,
			timer_prescale_select, deadband_count, pin_dir_a, pin_dir_b};
		calm_next = (ctl_next != ctl_reg) ? 11'h000 : calm_reg + {10'h000, ~&calm_reg};
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctl_reg  <= '0;
			calm_reg <= 11'h000;
		end else begin
			ctl_reg  <= ctl_next;
			calm_reg <= calm_next;
		end
	end

	// a control that moves this cycle is not yet in calm_reg, so look at it directly
	assign calm = calm_reg >= HOLD && ctl_next == ctl_reg && polarity_mode_bits == 4'hC && !pin_dir_a && !pin_dir_b;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// ==========================================================
	// timer and duty
	a_timer_step: assert property ($changed(period_timer) |->
		period_timer == $past(period_timer) + 8'h01 || period_timer == '0) else $error("timer step wrong");
	a_timer_wrap: assert property ($changed(period_timer) && $past(period_timer) == $past(period_limit)
		|-> period_timer == '0) else $error("timer did not clear at limit");
	a_tick_spacing: assert property ($changed(period_timer) && timer_prescale_select == `EBP_PSC_SEL_1
		|=> $stable(period_timer) [*3] ##1 $changed(period_timer)) else $error("timer tick not four clocks");
	a_duty_boundary: assert property ($changed(duty_active) |-> period_timer == '0)
		else $error("duty buffer moved mid period");
	a_post_start: assert property (post_tick |-> period_timer == '0)
		else $error("post tick away from period start");
	a_zero_idle: assert property (calm && output_config_field == `EBP_CFG_SINGLE && duty_active == '0
		&& $past(duty_active, 2) == '0 |-> !out_a) else $error("zero duty drove output");

	// ==========================================================
	// output configurations
	a_oe_gate: assert property (pin_dir_a && $past(pin_dir_a) && $past(pin_dir_a, 2) |-> !out_a_oe)
		else $error("input pin still driven");
	a_unused_quiet: assert property (calm && output_config_field == `EBP_CFG_SINGLE
		|-> !out_b_oe && !out_c_oe) else $error("unused pin driven in single mode");
	a_full_fwd: assert property (calm && output_config_field == `EBP_CFG_FWD
		|-> out_a && !out_b && !out_c) else $error("forward pins wrong");
	a_full_rev: assert property (calm && output_config_field == `EBP_CFG_REV
		|-> out_c && !out_a && !out_d) else $error("reverse pins wrong");
	a_half_compl: assert property (calm && output_config_field == `EBP_CFG_HALF && deadband_count == '0
		|-> out_b == !out_a) else $error("half bridge not complementary");
	a_dir_swap: assert property ($changed(period_timer) && period_timer == period_limit && out_a
		&& out_c_oe && !out_c && polarity_mode_bits == 4'hC && output_config_field == `EBP_CFG_REV
		&& $past(output_config_field) == `EBP_CFG_REV
		|-> ##[1:3] (out_c && !out_a && !out_b && !out_d)) else $error("direction swap late");

	c_half_db: cover property (calm && output_config_field == `EBP_CFG_HALF && deadband_count != '0 && $rose(out_a));
	c_dir: cover property ($changed(period_timer) && period_timer == period_limit && out_a && out_c_oe
		&& output_config_field == `EBP_CFG_REV);
	c_post: cover property (post_tick);
endmodule

bind ebp_top ebp_top_asserts #(.TW(TW), .DW(DW), .DBW(DBW)) u_asserts (.*);

/* File: verif/ebp_bridge_model.sv */
// Purpose: gate driver side of the bridge, legs A/B and C/D
// Assumes: active-high drive levels
// Notes:   counts cycles where both switches of one leg would conduct
`timescale 1ns/1ps

module ebp_bridge_model (
	input  wire logic       mclk,
	input  wire logic [3:0] drv,
	input  wire logic [3:0] oe,
	output logic      [3:0] pin,
	output int              shoot_cnt = 0
);
	// undriven pins sit on the board pull-down, so switches stay off
	assign pin = drv & oe;

	// shoot-through watch on both legs
	always @(posedge mclk) begin
		if ((pin[0] & pin[1]) | (pin[2] & pin[3])) begin
			shoot_cnt <= shoot_cnt + 1;
		end
	end
endmodule

/* File: verif/ebp_top_test.sv */
// Purpose: self-checking bench of the bridge pwm output stage
// Assumes: 40 MHz mclk, ce held high
// Notes:   high times counted on model pins over whole periods, so phase is free
`timescale 1ns/1ps
`include "ebp_defs.svh"

module ebp_top_test;
	logic       mclk                  = 1'b0;
	logic       rst                   = 1'b1;
	logic       ce                    = 1'b1;
	logic [3:0] polarity_mode_bits    = 4'h0;
	logic [3:0] postscale_select      = 4'h0;
	logic [1:0] output_config_field   = 2'h0;
	logic [1:0] duty_low_bits         = 2'h0;
	logic [1:0] timer_prescale_select = 2'h0;
	logic [7:0] duty_pending          = 8'h00;
	logic [7:0] period_limit          = 8'h07;
	logic [6:0] deadband_count        = 7'h00;
	logic       pin_dir_a             = 1'b0;
	logic       pin_dir_b             = 1'b0;
	logic       pin_dir_c             = 1'b0;
	logic       pin_dir_d             = 1'b0;
	logic       out_a, out_b, out_c, out_d, post_tick;
	logic       out_a_oe, out_b_oe, out_c_oe, out_d_oe;
	logic [9:0] duty_active;
	logic [7:0] period_timer;
	logic [3:0] pin;
	int         shoot_cnt;
	int         error_cnt = 0;
	int         checked   = 0;
	int         per       = 32;
	int         wraps, posts;
	int         hi [4];
	logic [9:0] dl [3]    = '{10'h000, 10'h00C, 10'h3FF};
	int         dh [3]    = '{0, 12, 32};

	ebp_top dut (.*);
	ebp_bridge_model u_model (.mclk(mclk), .drv({out_d, out_c, out_b, out_a}),
		.oe({out_d_oe, out_c_oe, out_b_oe, out_a_oe}), .pin(pin), .shoot_cnt(shoot_cnt));

	initial begin
		forever #12.5 mclk = ~mclk;
	end

	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t ns: seen %0d expected %0d", $time, seen, exp);
		end
	endtask

	// reset is also the only moment the prescaler moves, so tick checks stay valid
	task automatic rst_cfg(input logic [1:0] ps, input logic [7:0] lim);
		@(posedge mclk);
		rst                   <= 1'b1;
		timer_prescale_select <= ps;
		period_limit          <= lim;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		per = (lim + 1) * 4 * (1 << (2 * ps));
	endtask

	// settle twenty periods so double buffers fill, and the checker's calm window too for periods of 30 clocks or more
	task automatic set(input logic [3:0] m, input logic [1:0] c, input logic [9:0] d, input logic [6:0] db);
		@(posedge mclk);
		polarity_mode_bits                <= m;
		output_config_field               <= c;
		{duty_pending, duty_low_bits}     <= d;
		deadband_count                    <= db;
		repeat (20 * per) @(posedge mclk);
	endtask

	task automatic measure(input int n);
		logic [7:0] last;
		hi    = '{default: 0};
		wraps = 0;
		posts = 0;
		last  = period_timer;
		repeat (n * per) begin
			@(negedge mclk);
			for (int k = 0; k < 4; k++) hi[k] += pin[k];
			wraps += (period_timer == 8'h00 && last != 8'h00);
			posts += post_tick;
			last = period_timer;
		end
	endtask

	task automatic wrap_up;
		if (error_cnt == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ==========================================================
	// tests
	initial begin
		rst_cfg(2'h0, 8'h07);
		// each prescale factor, duty split over pending and low bits
		for (int i = 0; i < 3; i++) begin
			rst_cfg(i[1:0], 8'h03);
			set(4'hC, `EBP_CFG_SINGLE, 10'd6, 7'h00);
			measure(2);
			chk(wraps, 2);
			chk(hi[0], 12 * (1 << (2 * i)));
			chk(duty_active, 10'd6);
		end
		rst_cfg(2'h0, 8'h07);
		@(posedge mclk);
		postscale_select <= 4'h1;
		// zero, mid and over-period duty
		for (int i = 0; i < 3; i++) begin
			set(4'hC, `EBP_CFG_SINGLE, dl[i], 7'h00);
			measure(4);
			chk(hi[0], 4 * dh[i]);
		end
		chk(wraps, 4);
		chk(posts, 2);
		set(4'hF, `EBP_CFG_SINGLE, 10'd12, 7'h00);
		measure(4);
		chk(hi[0], 80);
		set(4'hC, `EBP_CFG_SINGLE, 10'd12, 7'h00);
		@(posedge mclk);
		pin_dir_a <= 1'b1;
		// let the enable flop see the input pin before counting
		@(posedge mclk);
		measure(4);
		chk(hi[0], 0);
		@(posedge mclk);
		pin_dir_a <= 1'b0;
		// half bridge without, with short and with oversized dead-band
		set(4'hC, `EBP_CFG_HALF, 10'd12, 7'h00);
		measure(4);
		chk(hi[0], 48);
		chk(hi[1], 80);
		set(4'hC, `EBP_CFG_HALF, 10'd12, 7'h02);
		measure(4);
		chk(hi[0] >= 4 && hi[0] <= 28, 1);
		chk(hi[1] >= 36 && hi[1] <= 60, 1);
		set(4'hC, `EBP_CFG_HALF, 10'd12, 7'h14);
		measure(4);
		chk(hi[0] + hi[1], 0);
		// full bridge forward, then duty cut before reversing
		set(4'hC, `EBP_CFG_FWD, 10'd12, 7'h05);
		measure(4);
		chk(hi[0], 128);
		chk(hi[3], 48);
		chk(hi[1] + hi[2], 0);
		set(4'hC, `EBP_CFG_FWD, 10'd4, 7'h05);
		set(4'hC, `EBP_CFG_REV, 10'd4, 7'h05);
		measure(4);
		chk(hi[2], 128);
		chk(hi[1], 16);
		chk(hi[0] + hi[3], 0);
		chk(shoot_cnt, 0);
		wrap_up();
	end

	// hang guard, well past the expected run length
	initial begin
		#1500000;
		error_cnt++;
		wrap_up();
	end
endmodule
